/* hdl/cfh_channel.sv */
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cfh_cfg.svh"
// Notes on behaviour
// R1 - hysteresis activates when comparison becomes true
// R2 - pulse mode: equality sets output, arms hysteresis
// R3 - active hysteresis freezes the comparison result
// R4 - rearm only on fresh comparison hit
// R5 - pulse mode: leave band above, clear output
// R6 - equality during hysteresis keeps output, no retrigger
// R7 - frequency mode counts rising edges per window
// R8 - window 10 to 10000 ms, 1 ms steps
// R9 - result updates only after full window
// R10 - no edge in window reports zero
// R11 - result is in millihertz
// R12 - each channel has its own logic
// R13 - frequency measured on input B
// R14 - interrupt select: none, process, diag plus process
// R15 - diagnostic only for lost hardware interrupt
// R16 - end of window raises hardware interrupt
// R17 - frequency mode ignores comparison parameters
// R18 - hysteresis band 0 to 255 counts
// R19 - hysteresis of 0 or 1 disables it
// R20 - zero pulse: output follows comparison condition
// R21 - software gate starts, stops, restarts window
// R22 - millihertz = edges times million over ms
module cfh_channel import cfh_pkg::*; #(
  parameter int unsigned CYC_PER_MS = `CFH_TIMEBASE_NS / `CFH_CLK_PERIOD_NS // Clocks per ms
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic reset, // Async reset, active high
  input wire cfh_avs_req_t avs_req, // Avalon-MM request
  output logic [31:0] avs_readdata, // Avalon-MM read data
  output logic avs_waitrequest, // Avalon-MM wait request
  input wire logic chan_in_a, // Pulse input A, asynchronous
  input wire logic chan_in_b, // Input B, asynchronous
  output logic compare_out, // Compare output
  output logic hw_irq, // Hardware interrupt, one-cycle pulse
  output logic diag_irq // Lost-interrupt diagnostic, one-cycle pulse
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic wreq; // Wait request
    logic [31:0] rdata; // Read data
    logic freq_mode; // Frequency measurement selected
    logic gate; // software_gate_enable
    logic [1:0] cmp_mode; // Comparison mode
    logic [1:0] irq_sel; // Interrupt selection
    logic eom_en; // End-of-measurement interrupt enable
    logic [13:0] integ; // Integration time, ms
    logic [7:0] hyst; // Hysteresis band
    logic [31:0] cmp_val; // Comparison value
    logic [31:0] count; // Counter value
    logic [31:0] meas; // measured_frequency_value
    logic flag; // comparator_result_flag
    logic hyst_act; // Hysteresis active
    logic cond_prev; // Condition one cycle earlier
    logic cmp_out; // Compare output
    logic pend; // Hardware interrupt pending
    logic [2:0] a_sync; // Sync chain and edge history, A
    logic [2:0] b_sync; // Sync chain and edge history, B
    cfh_win_t win; // Window sequencer
    logic [15:0] tick; // Clocks within current ms
    logic [13:0] ms; // Ms within current window
    logic [13:0] win_len; // Length of running window
    logic [31:0] edges; // Edges in running window
    logic [31:0] cap; // Edges of finished window
    logic div_go; // Start divider
    logic hw_irq; // Interrupt pulse
    logic diag_irq; // Diagnostic pulse
  } cfh_state_t;
  cfh_state_t s_q, s_d;

  logic req; // Request present
  logic acc; // Access completes this edge
  logic cond; // Comparison condition
  logic band; // Counter inside hysteresis band
  logic hyst_on; // Hysteresis enabled
  logic cmp_run; // Comparator in use
  logic a_rise; // Rising edge on A
  logic b_rise; // Rising edge on B
  logic win_end; // Window expires this edge
  logic div_done; // Divider result valid
  logic [31:0] div_q; // Divider result
  logic [51:0] dividend; // Edges times one million

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Counter within cmp - h .. cmp + h, computed without wrap
  function automatic logic in_band(input logic [31:0] c, input logic [31:0] v,
                                   input logic [7:0] h);
    logic [32:0] lo;
    logic [32:0] hi;
    lo = (v >= {24'h00_0000, h}) ? {1'b0, v - {24'h00_0000, h}} : 33'h0_0000_0000;
    hi = {1'b0, v} + {25'h000_0000, h};
    return ({1'b0, c} >= lo) && ({1'b0, c} <= hi);
  endfunction

  // Keep the integration time within its legal range
  function automatic logic [13:0] clamp_integ(input logic [31:0] v);
    if (v < {18'h0_0000, `CFH_INTEG_MIN}) begin
      return `CFH_INTEG_MIN;
    end else if (v > {18'h0_0000, `CFH_INTEG_MAX}) begin
      return `CFH_INTEG_MAX;
    end
    return v[13:0];
  endfunction

  // ----------------------------------------
  // Divider for the millihertz result
  // ----------------------------------------
  assign dividend = 52'(s_q.cap) * 52'(`CFH_MHZ_SCALE); // R22 R11
  // Private divider, nothing shared with other channels
  cfh_div #(.NW(52), .DW(14)) u_div ( // R12
    .clk(clk),
    .reset(reset),
    .start(s_q.div_go),
    .dividend(dividend),
    .divisor(s_q.win_len),
    .done(div_done),
    .quotient(div_q)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.hw_irq = 1'b0;
    s_d.diag_irq = 1'b0;
    s_d.div_go = 1'b0;
    win_end = 1'b0;
    // Input synchronisers, third stage keeps history
    s_d.a_sync = {s_q.a_sync[1:0], chan_in_a};
    s_d.b_sync = {s_q.b_sync[1:0], chan_in_b};
    a_rise = s_q.a_sync[1] & ~s_q.a_sync[2];
    b_rise = s_q.b_sync[1] & ~s_q.b_sync[2]; // R13

    // Pulse counting on A outside frequency mode
    if (!s_q.freq_mode && a_rise) begin
      s_d.count = s_q.count + 32'h0000_0001;
    end

    // Bus slave: wait one cycle, then complete
    req = avs_req.read | avs_req.write;
    acc = req & ~s_q.wreq;
    s_d.wreq = ~(req & s_q.wreq);
    if (req && s_q.wreq && avs_req.read) begin
      case (avs_req.address)
        `CFH_OFS_CTRL: begin
          s_d.rdata = {25'h000_0000, s_q.eom_en, s_q.irq_sel, s_q.cmp_mode, s_q.gate,
                       s_q.freq_mode};
        end
        `CFH_OFS_INTEG: s_d.rdata = {18'h0_0000, s_q.integ};
        `CFH_OFS_HYST: s_d.rdata = {24'h00_0000, s_q.hyst};
        `CFH_OFS_CMP: s_d.rdata = s_q.cmp_val;
        `CFH_OFS_COUNT: s_d.rdata = s_q.count;
        `CFH_OFS_MEAS: s_d.rdata = s_q.meas;
        `CFH_OFS_STATUS: begin
          s_d.rdata = {27'h000_0000, s_q.pend, s_q.win == CFH_RUN, s_q.cmp_out,
                       s_q.hyst_act, s_q.flag};
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && avs_req.write) begin
      case (avs_req.address)
        `CFH_OFS_CTRL: begin
          if (avs_req.byteenable[0]) begin
            s_d.freq_mode = avs_req.writedata[`CFH_CTL_FREQ];
            s_d.gate = avs_req.writedata[`CFH_CTL_GATE];
            s_d.cmp_mode = avs_req.writedata[`CFH_CTL_CMP_LO +: 2];
            s_d.irq_sel = avs_req.writedata[`CFH_CTL_IRQ_LO +: 2]; // R14
            s_d.eom_en = avs_req.writedata[`CFH_CTL_EOM];
          end
        end
        `CFH_OFS_INTEG: begin
          s_d.integ = clamp_integ(be_merge({18'h0_0000, s_q.integ}, avs_req.writedata,
                                           avs_req.byteenable)); // R8
        end
        `CFH_OFS_HYST: begin
          if (avs_req.byteenable[0]) begin
            s_d.hyst = avs_req.writedata[7:0]; // R18
          end
        end
        `CFH_OFS_CMP: s_d.cmp_val = be_merge(s_q.cmp_val, avs_req.writedata, avs_req.byteenable);
        `CFH_OFS_COUNT: s_d.count = be_merge(s_q.count, avs_req.writedata, avs_req.byteenable);
        `CFH_OFS_STATUS: begin
          // Write one clears pending; a new event below wins
          if (avs_req.byteenable[0] && avs_req.writedata[`CFH_STS_PEND]) begin
            s_d.pend = 1'b0;
          end
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end

    // Comparator with hysteresis, unused in frequency mode
    cmp_run = !s_q.freq_mode && (s_q.cmp_mode != `CFH_CMP_NONE); // R17
    hyst_on = s_q.hyst > `CFH_HYST_OFF; // R19
    band = in_band(s_q.count, s_q.cmp_val, s_q.hyst);
    case (s_q.cmp_mode)
      `CFH_CMP_GE: cond = s_q.count >= s_q.cmp_val;
      `CFH_CMP_LE: cond = s_q.count <= s_q.cmp_val;
      `CFH_CMP_PULSE: cond = s_q.count == s_q.cmp_val;
      default: cond = 1'b0;
    endcase
    if (!cmp_run) begin
      s_d.flag = 1'b0;
      s_d.hyst_act = 1'b0;
      s_d.cond_prev = 1'b0;
    end else begin
      s_d.cond_prev = cond;
      if (s_q.hyst_act) begin
        // Result frozen while inside the band
        if (!band) begin // R3 R6
          s_d.hyst_act = 1'b0;
          if (s_q.cmp_mode == `CFH_CMP_PULSE && s_q.count > s_q.cmp_val) begin
            s_d.flag = 1'b0; // R5
          end else begin
            s_d.flag = cond;
          end
        end
      end else if (cond && !s_q.cond_prev && hyst_on) begin
        // Fresh hit: set result and arm hysteresis
        s_d.flag = 1'b1; // R1 R2 R4
        s_d.hyst_act = 1'b1;
      end else begin
        s_d.flag = cond; // R20
      end
    end
    s_d.cmp_out = s_d.flag;

    // Frequency measurement window sequencer
    case (s_q.win)
      CFH_IDLE: begin
        if (s_q.freq_mode && s_q.gate) begin
          s_d.win = CFH_RUN; // R21
          s_d.tick = '0;
          s_d.ms = '0;
          s_d.edges = '0;
          s_d.win_len = s_q.integ;
        end
      end
      CFH_RUN: begin
        if (!(s_q.freq_mode && s_q.gate)) begin
          s_d.win = CFH_IDLE; // R21
        end else begin
          if (b_rise && s_q.edges != 32'hFFFF_FFFF) begin
            s_d.edges = s_q.edges + 32'h0000_0001; // R7
          end
          if (s_q.tick == 16'(CYC_PER_MS - 1)) begin
            s_d.tick = '0;
            if (s_q.ms == s_q.win_len - 14'h0001) begin
              win_end = 1'b1;
              s_d.ms = '0;
              s_d.cap = s_d.edges; // R10
              s_d.edges = '0;
              s_d.div_go = 1'b1;
              s_d.win_len = s_q.integ;
            end else begin
              s_d.ms = s_q.ms + 14'h0001;
            end
          end else begin
            s_d.tick = s_q.tick + 16'h0001;
          end
        end
      end
      default: s_d.win = CFH_IDLE;
    endcase

    // Result changes only when a window has been divided out
    if (div_done) begin
      s_d.meas = div_q; // R9
    end

    // End-of-measurement interrupt and lost-interrupt diagnostic
    if (win_end && s_q.eom_en && s_q.irq_sel != `CFH_IRQ_NONE) begin
      s_d.hw_irq = 1'b1; // R16
      s_d.pend = 1'b1;
      if (s_q.pend && s_q.irq_sel == `CFH_IRQ_DIAG) begin
        s_d.diag_irq = 1'b1; // R15
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.wreq <= 1'b1;
      s_q.integ <= `CFH_INTEG_RST;
      s_q.win_len <= `CFH_INTEG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wreq;
  assign compare_out = s_q.cmp_out;
  assign hw_irq = s_q.hw_irq;
  assign diag_irq = s_q.diag_irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  bus_answer_a: assert property (req && s_q.wreq |=> !s_q.wreq)
    else $error("waitrequest did not drop");
  hyst_arm_a: assert property (cmp_run && !s_q.hyst_act && cond && !s_q.cond_prev && hyst_on
    |=> s_q.hyst_act && s_q.flag) else $error("hysteresis not armed"); // R1
  pulse_set_a: assert property (cmp_run && s_q.cmp_mode == `CFH_CMP_PULSE && !s_q.hyst_act
    && s_q.count == s_q.cmp_val |=> compare_out) else $error("pulse output not set"); // R2
  hyst_freeze_a: assert property (cmp_run && s_q.hyst_act && band && !acc
    |=> $stable(s_q.flag)) else $error("result moved in band"); // R3
  pulse_clear_a: assert property (cmp_run && s_q.cmp_mode == `CFH_CMP_PULSE && s_q.hyst_act
    && !band && s_q.count > s_q.cmp_val |=> !compare_out && !s_q.hyst_act)
    else $error("output not cleared"); // R5
  meas_hold_a: assert property (!div_done |=> $stable(s_q.meas))
    else $error("result changed mid window"); // R9
  eom_irq_a: assert property (win_end && s_q.eom_en && s_q.irq_sel != `CFH_IRQ_NONE
    |=> hw_irq ##1 !hw_irq) else $error("end interrupt missing"); // R16
  diag_lost_a: assert property (diag_irq |-> hw_irq && $past(s_q.pend)
    && $past(s_q.irq_sel) == `CFH_IRQ_DIAG) else $error("stray diagnostic"); // R15
  integ_range_a: assert property (s_q.integ >= `CFH_INTEG_MIN && s_q.integ <= `CFH_INTEG_MAX)
    else $error("integration time out of range"); // R8
  freq_ignore_a: assert property (s_q.freq_mode |=> !compare_out)
    else $error("compare active in frequency mode"); // R17
endmodule

/* hdl/cfh_cfg.svh */
`ifndef CFH_CFG_SVH
`define CFH_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFH_OFS_CTRL 8'h00
`define CFH_OFS_INTEG 8'h04
`define CFH_OFS_HYST 8'h08
`define CFH_OFS_CMP 8'h0C
`define CFH_OFS_COUNT 8'h10
`define CFH_OFS_MEAS 8'h14
`define CFH_OFS_STATUS 8'h18
// ----------------------------------------
// Control and status bit positions
// ----------------------------------------
`define CFH_CTL_FREQ 0
`define CFH_CTL_GATE 1
`define CFH_CTL_CMP_LO 2
`define CFH_CTL_IRQ_LO 4
`define CFH_CTL_EOM 6
`define CFH_STS_FLAG 0
`define CFH_STS_HYST 1
`define CFH_STS_OUT 2
`define CFH_STS_GATE 3
`define CFH_STS_PEND 4
// ----------------------------------------
// Field encodings
// ----------------------------------------
`define CFH_CMP_NONE 2'h0
`define CFH_CMP_GE 2'h1
`define CFH_CMP_LE 2'h2
`define CFH_CMP_PULSE 2'h3
`define CFH_IRQ_NONE 2'h0
`define CFH_IRQ_PROC 2'h1
`define CFH_IRQ_DIAG 2'h2
`define CFH_HYST_OFF 8'h01
// ----------------------------------------
// Reset values, limits and timing
// ----------------------------------------
`define CFH_INTEG_MIN 14'h000A
`define CFH_INTEG_MAX 14'h2710
`define CFH_INTEG_RST 14'h0064
`define CFH_MHZ_SCALE 20'hF_4240
`define CFH_CLK_PERIOD_NS 20
`define CFH_TIMEBASE_NS 1000000
`endif

/* hdl/cfh_pkg.sv */
package cfh_pkg;
  // Avalon-MM request from the bus master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } cfh_avs_req_t;
  // Integration window sequencer
  typedef enum logic {CFH_IDLE, CFH_RUN} cfh_win_t;
endpackage

/* hdl/cfh_div.sv */
`timescale 1ns/1ps
// Restoring divider, one quotient bit per clock
module cfh_div import cfh_pkg::*; #(
  parameter int NW = 52, // Dividend width
  parameter int DW = 14 // Divisor width
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic start, // Load operands, one-cycle pulse
  input wire logic [NW-1:0] dividend, // Numerator
  input wire logic [DW-1:0] divisor, // Denominator, never zero
  output logic done, // Quotient valid, one-cycle pulse
  output logic [31:0] quotient // Saturated quotient
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] idx;
    logic [NW-1:0] quot;
    logic [DW-1:0] rem;
    logic [DW-1:0] dvs;
  } cfh_div_t;
  cfh_div_t s_q, s_d;
  logic [DW:0] shifted; // Partial remainder after shift

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    shifted = {s_q.rem, s_q.quot[NW-1]};
    if (start) begin
      s_d.busy = 1'b1;
      s_d.idx = 6'(NW - 1);
      s_d.quot = dividend;
      s_d.rem = '0;
      s_d.dvs = divisor;
    end else if (s_q.busy) begin
      // Subtract when the divisor fits
      if (shifted >= {1'b0, s_q.dvs}) begin
        s_d.rem = DW'(shifted - {1'b0, s_q.dvs});
        s_d.quot = {s_q.quot[NW-2:0], 1'b1};
      end else begin
        s_d.rem = shifted[DW-1:0];
        s_d.quot = {s_q.quot[NW-2:0], 1'b0};
      end
      if (s_q.idx == 6'h00) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.idx = s_q.idx - 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign quotient = (|s_q.quot[NW-1:32]) ? 32'hFFFF_FFFF : s_q.quot[31:0];
endmodule

/* test/cfh_pulse_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// External pulse source on one channel input
// ----------------------------------------
module cfh_pulse_src (
  input wire logic clk, // System clock
  output logic line // Driven channel input
);
  // Line idles low between bursts
  initial begin
    line = 1'b0;
  end
  // Emits n pulses, high for hw clocks, low for hw+1 clocks between pulses
  task automatic burst(input int n, input int hw);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) line <= 1'b1;
      repeat (hw) @(posedge clk);
      line <= 1'b0;
      repeat (hw) @(posedge clk);
    end
  endtask
endmodule

/* test/counter_frequency_hysteresis_bench.sv */
`timescale 1ns/1ps
`include "cfh_cfg.svh"
module counter_frequency_hysteresis_bench import cfh_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int CPM = 10; // Short millisecond for simulation
  logic clk, reset; // Clock and reset
  cfh_avs_req_t avs_req; // Bus request
  logic [31:0] avs_readdata; // Bus read data
  logic avs_waitrequest, chan_in_a, chan_in_b, compare_out, hw_irq, diag_irq;
  int fails, samples_checked, cyc; // Counters
  logic [31:0] rd; // Last read data
  logic dg; // Diagnostic seen with last interrupt
  cfh_channel #(.CYC_PER_MS(CPM)) uut (.clk(clk), .reset(reset), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_in_a(chan_in_a),
    .chan_in_b(chan_in_b), .compare_out(compare_out), .hw_irq(hw_irq), .diag_irq(diag_irq));
  cfh_pulse_src src_a (.clk(clk), .line(chan_in_a));
  cfh_pulse_src src_b (.clk(clk), .line(chan_in_b));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Verdict and end of run
  task automatic test_done();
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_req.read <= !wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    avs_req.byteenable <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    chk("bus_wait", 32'h0000_0000, {31'h0, n >= 100});
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  // Waits for the next interrupt pulse, counting clocks
  task automatic wait_irq();
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while (hw_irq !== 1'b1 && cyc < 2000);
    dg = diag_irq;
    chk("irq_wait", 32'h0000_0000, {31'h0, cyc >= 2000});
  endtask
  // Watches for any interrupt over n clocks
  task automatic no_irq(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (hw_irq !== 1'b0) seen = 1'b1;
    end
    chk("no_irq", 32'h0000_0000, {31'h0, seen});
  endtask
  // Loads the counter, then checks output and band state
  task automatic step(input logic [31:0] c, input logic eo, input logic eh);
    bus(1'b1, `CFH_OFS_COUNT, c);
    repeat (3) @(posedge clk);
    chk("compare_out", {31'h0, eo}, {31'h0, compare_out});
    bus(1'b0, `CFH_OFS_STATUS, 32'h0000_0000);
    chk("hyst_active", {31'h0, eh}, {31'h0, rd[`CFH_STS_HYST]});
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cuts a hang short
  initial begin
    #300000;
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    test_done();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    avs_req = '0;
    fails = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // Reset values and an unmapped place
    bus(1'b0, `CFH_OFS_INTEG, 32'h0000_0000);
    chk("integ_rst", 32'h0000_0064, rd);
    bus(1'b0, `CFH_OFS_HYST, 32'h0000_0000);
    chk("hyst_rst", 32'h0000_0000, rd);
    bus(1'b0, `CFH_OFS_MEAS, 32'h0000_0000);
    chk("meas_rst", 32'h0000_0000, rd);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    // Integration time limits
    bus(1'b1, `CFH_OFS_INTEG, 32'h0000_0005);
    bus(1'b0, `CFH_OFS_INTEG, 32'h0000_0000);
    chk("integ_min", 32'h0000_000A, rd);
    bus(1'b1, `CFH_OFS_INTEG, 32'h0000_4E20);
    bus(1'b0, `CFH_OFS_INTEG, 32'h0000_0000);
    chk("integ_max", 32'h0000_2710, rd);
    bus(1'b1, `CFH_OFS_INTEG, 32'h0000_000A);
    bus(1'b1, `CFH_OFS_HYST, 32'h0000_00FF);
    bus(1'b0, `CFH_OFS_HYST, 32'h0000_0000);
    chk("hyst_max", 32'h0000_00FF, rd);
    // Pulse at comparison value with a band of 3
    bus(1'b1, `CFH_OFS_HYST, 32'h0000_0003);
    bus(1'b1, `CFH_OFS_CMP, 32'h0000_0064);
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_000C);
    step(32'h0000_0063, 1'b0, 1'b0);
    step(32'h0000_0064, 1'b1, 1'b1);
    step(32'h0000_0066, 1'b1, 1'b1);
    step(32'h0000_0064, 1'b1, 1'b1);
    step(32'h0000_0068, 1'b0, 1'b0);
    step(32'h0000_0066, 1'b0, 1'b0);
    step(32'h0000_0064, 1'b1, 1'b1);
    step(32'h0000_0068, 1'b0, 1'b0);
    // Greater-or-equal with band of 1, which disables it
    bus(1'b1, `CFH_OFS_HYST, 32'h0000_0001);
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0004);
    step(32'h0000_0065, 1'b1, 1'b0);
    step(32'h0000_0063, 1'b0, 1'b0);
    // Less-or-equal, then no comparison at all
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0008);
    step(32'h0000_0063, 1'b1, 1'b0);
    step(32'h0000_0065, 1'b0, 1'b0);
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0000);
    step(32'h0000_0063, 1'b0, 1'b0);
    // Input A counts pulses outside frequency mode
    src_a.burst(2, 2);
    bus(1'b0, `CFH_OFS_COUNT, 32'h0000_0000);
    chk("count_a", 32'h0000_0065, rd);
    // Frequency on input B while A also pulses
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0053);
    wait_irq();
    fork
      src_b.burst(5, 2);
      src_a.burst(3, 2);
    join
    wait_irq();
    repeat (70) @(posedge clk);
    bus(1'b0, `CFH_OFS_MEAS, 32'h0000_0000);
    chk("meas", (32'h0000_0005 * `CFH_MHZ_SCALE) / 32'h0000_000A, rd);
    wait_irq();
    bus(1'b0, `CFH_OFS_MEAS, 32'h0000_0000);
    chk("meas_hold", (32'h0000_0005 * `CFH_MHZ_SCALE) / 32'h0000_000A, rd);
    wait_irq();
    wait_irq();
    chk("window", 10 * CPM, cyc);
    chk("diag_proc", 32'h0000_0000, {31'h0, dg});
    bus(1'b0, `CFH_OFS_MEAS, 32'h0000_0000);
    chk("meas_zero", 32'h0000_0000, rd);
    // Gate closed, then reopened for a full window
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0051);
    no_irq(250);
    bus(1'b0, `CFH_OFS_STATUS, 32'h0000_0000);
    chk("gate_sts", 32'h0000_0000, {31'h0, rd[`CFH_STS_GATE]});
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0053);
    wait_irq();
    chk("restart", 32'h0000_0001, {31'h0, cyc >= 100 && cyc <= 106});
    // Interrupt selection none, then diagnostics
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0043);
    no_irq(250);
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0041);
    bus(1'b1, `CFH_OFS_STATUS, 32'h0000_0010);
    bus(1'b1, `CFH_OFS_CTRL, 32'h0000_0063);
    wait_irq();
    chk("diag_first", 32'h0000_0000, {31'h0, dg});
    wait_irq();
    chk("diag_lost", 32'h0000_0001, {31'h0, dg});
    test_done();
  end
endmodule
